// ### lps_seq_top.sv
// light and proximity sequencer: shared package and top-level sequencer with interrupt logic
//
// The address-and-strobe port and the address map were decided locally.
`default_nettype none
// Operation
// - the ambient and proximity channels are sequenced by separate timers and may convert at once.
// - the ambient channel completes one conversion for every 100 ms sample period.
// - each proximity reading switches the emitter driver on and converts over about 540 us.
// - the emitter driver is on for 100 us per reading and readings repeat at 800 ms or faster.
// - an ambient trigger is raised when a result lies below the low or above the high threshold.
// - a proximity trigger is raised when a result lies above the proximity threshold.
// - ambient and proximity thresholds are held in separate, independently written registers.
// - a selectable count of 1, 4, 8 or 16 consecutive triggers is needed before an interrupt.
// - in combined mode only ambient and proximity triggers together, counted as above, interrupt.
// - an interrupt event sets a readable status bit and, where its mask bit is set, drives the hardware interrupt output.
// - the interrupt output is open drain: it only pulls the line low, otherwise it is released.
// - the ambient result is a 12-bit count that saturates at 4095.
// - the proximity result is an 8-bit count that saturates at 255.
package lps_pkg;
  // clock and timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int AMB_PERIOD_MS   = 100;
  localparam int AMB_PERIOD_CYC  = (CLK_HZ / 1000) * AMB_PERIOD_MS;
  localparam int PROX_PERIOD_MS  = 800;
  localparam int PROX_PERIOD_CYC = (CLK_HZ / 1000) * PROX_PERIOD_MS;
  localparam int EMIT_ON_US      = 100;
  localparam int EMIT_ON_CYC     = (CLK_HZ / 1_000_000) * EMIT_ON_US;
  localparam int PROX_CONV_US    = 540;
  localparam int PROX_CONV_CYC   = (CLK_HZ / 1_000_000) * PROX_CONV_US;
  localparam int TMR_W           = 25;
  // data widths and full scale
  localparam int AMB_W           = 12;
  localparam int PROX_W          = 8;
  localparam int AMB_RAW_W       = 16;
  localparam int PROX_RAW_W      = 10;
  localparam logic [11:0] AMB_FULL  = 12'h0fff;
  localparam logic [7:0]  PROX_FULL = 8'h0ff;
  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_AMB_LO    = 8'h01;
  localparam logic [7:0] OFS_AMB_HI    = 8'h02;
  localparam logic [7:0] OFS_PROX_THR  = 8'h03;
  localparam logic [7:0] OFS_AMB_DATA  = 8'h04;
  localparam logic [7:0] OFS_PROX_DATA = 8'h05;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h06;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h07;
  // control field positions
  localparam int CTRL_AMB_EN  = 0;
  localparam int CTRL_PROX_EN = 1;
  localparam int CTRL_COMB    = 2;
  localparam int CTRL_PERS_LO = 3;
  localparam int CTRL_SLP_LO  = 5;
  localparam int CTRL_W       = 8;
  // status bit positions
  localparam int IRQ_AMB  = 0;
  localparam int IRQ_PROX = 1;
  localparam int IRQ_COMB = 2;
  localparam int IRQ_W    = 3;
  // reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [11:0] AMB_LO_RST   = 12'h0000;
  localparam logic [11:0] AMB_HI_RST   = 12'h0fff;
  localparam logic [7:0]  PROX_THR_RST = 8'h0ff;
  localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

  typedef struct packed {
    logic [2:0] prox_sleep;
    logic [1:0] persist_sel;
    logic       comb_mode;
    logic       prox_en;
    logic       amb_en;
  } lps_ctrl_type;

  typedef struct packed {
    logic [11:0] amb_lo;
    logic [11:0] amb_hi;
    logic [7:0]  prox;
  } lps_thr_type;

  typedef enum logic [1:0] {
    P_IDLE,
    P_EMIT,
    P_CONV
  } lps_prox_state_type;
endpackage

////////////////////////////////////////////////////////////////////////////////

module lps_seq_top
#(
  parameter int AMB_PERIOD  = lps_pkg::AMB_PERIOD_CYC,
  parameter int PROX_PERIOD = lps_pkg::PROX_PERIOD_CYC,
  parameter int PROX_CONV   = lps_pkg::PROX_CONV_CYC
)
(
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  input  wire logic [lps_pkg::ADDR_W-1:0]    addr,
  input  wire logic [lps_pkg::DATA_W-1:0]    wr_data,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  output logic      [lps_pkg::DATA_W-1:0]    rd_data,
  input  wire logic [lps_pkg::AMB_RAW_W-1:0] amb_raw,
  input  wire logic [lps_pkg::PROX_RAW_W-1:0] prox_raw,
  output logic                               emitter_sink_driver,
  output logic                               int_o,
  output logic                               int_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  lps_pkg::lps_ctrl_type            ctrl_q;
  lps_pkg::lps_thr_type             thr_q;
  logic [lps_pkg::IRQ_W-1:0]        stat_q;
  logic [lps_pkg::IRQ_W-1:0]        stat_d;
  logic [lps_pkg::IRQ_W-1:0]        mask_q;
  logic [lps_pkg::AMB_W-1:0]        amb_data_q;
  logic [lps_pkg::PROX_W-1:0]       prox_data_q;
  logic [lps_pkg::DATA_W-1:0]       rd_data_q;
  logic                             int_oe_q;
  logic                             emit_q;
  logic                             amb_trig_q;
  logic                             prox_trig_q;
  logic [lps_pkg::AMB_RAW_W-1:0]    amb_s1_q;
  logic [lps_pkg::AMB_RAW_W-1:0]    amb_s2_q;
  logic [lps_pkg::PROX_RAW_W-1:0]   prox_s1_q;
  logic [lps_pkg::PROX_RAW_W-1:0]   prox_s2_q;
  lps_pkg::lps_prox_state_type      pst_q;
  lps_pkg::lps_prox_state_type      pst_d;
  logic [lps_pkg::TMR_W-1:0]        pcnt_q;
  logic [lps_pkg::TMR_W-1:0]        pcnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  wire wr_ctrl  = wr_stb && (addr == lps_pkg::OFS_CTRL);
  wire wr_lo    = wr_stb && (addr == lps_pkg::OFS_AMB_LO);
  wire wr_hi    = wr_stb && (addr == lps_pkg::OFS_AMB_HI);
  wire wr_pthr  = wr_stb && (addr == lps_pkg::OFS_PROX_THR);
  wire wr_stat  = wr_stb && (addr == lps_pkg::OFS_IRQ_STAT);
  wire wr_mask  = wr_stb && (addr == lps_pkg::OFS_IRQ_MASK);
  wire [lps_pkg::IRQ_W-1:0] stat_clr = wr_stat ? wr_data[lps_pkg::IRQ_W-1:0] : '0;

  // unmapped offsets read as zero
  wire [lps_pkg::DATA_W-1:0] rd_mux =
    (addr == lps_pkg::OFS_CTRL)      ? {8'h00, ctrl_q} :
    (addr == lps_pkg::OFS_AMB_LO)    ? {4'h0, thr_q.amb_lo} :
    (addr == lps_pkg::OFS_AMB_HI)    ? {4'h0, thr_q.amb_hi} :
    (addr == lps_pkg::OFS_PROX_THR)  ? {8'h00, thr_q.prox} :
    (addr == lps_pkg::OFS_AMB_DATA)  ? {4'h0, amb_data_q} :
    (addr == lps_pkg::OFS_PROX_DATA) ? {8'h00, prox_data_q} :
    (addr == lps_pkg::OFS_IRQ_STAT)  ? {13'h0000, stat_q} :
    (addr == lps_pkg::OFS_IRQ_MASK)  ? {13'h0000, mask_q} : 16'h0000;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q    <= lps_pkg::CTRL_RST;
      mask_q    <= lps_pkg::IRQ_MASK_RST;
      rd_data_q <= 16'h0000;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= wr_data[lps_pkg::CTRL_W-1:0];
      if (wr_mask)
        mask_q <= wr_data[lps_pkg::IRQ_W-1:0];
      rd_data_q <= rd_stb ? rd_mux : 16'h0000;
    end
  end

  // each threshold has its own register, written on its own
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      thr_q.amb_lo <= lps_pkg::AMB_LO_RST;
      thr_q.amb_hi <= lps_pkg::AMB_HI_RST;
      thr_q.prox   <= lps_pkg::PROX_THR_RST;
    end
    else
    begin
      if (wr_lo)
        thr_q.amb_lo <= wr_data[lps_pkg::AMB_W-1:0];
      if (wr_hi)
        thr_q.amb_hi <= wr_data[lps_pkg::AMB_W-1:0];
      if (wr_pthr)
        thr_q.prox <= wr_data[lps_pkg::PROX_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter inputs: analogue side is asynchronous, two flops first

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      amb_s1_q  <= 16'h0000;
      amb_s2_q  <= 16'h0000;
      prox_s1_q <= 10'h000;
      prox_s2_q <= 10'h000;
    end
    else
    begin
      amb_s1_q  <= amb_raw;
      amb_s2_q  <= amb_s1_q;
      prox_s1_q <= prox_raw;
      prox_s2_q <= prox_s1_q;
    end
  end

  // clamp to full scale instead of wrapping
  wire [lps_pkg::AMB_W-1:0] amb_sat =
    (amb_s2_q > {4'h0, lps_pkg::AMB_FULL}) ? lps_pkg::AMB_FULL : amb_s2_q[11:0];
  wire [lps_pkg::PROX_W-1:0] prox_sat =
    (prox_s2_q > {2'h0, lps_pkg::PROX_FULL}) ? lps_pkg::PROX_FULL : prox_s2_q[7:0];
  wire amb_trig_now  = (amb_sat < thr_q.amb_lo) || (amb_sat > thr_q.amb_hi);
  wire prox_trig_now = prox_sat > thr_q.prox;

  ////////////////////////////////////////////////////////////////////////////
  // channel timers: two independent sequencers

  logic amb_tick;
  logic prox_tick;
  wire [lps_pkg::TMR_W-1:0] amb_period  = lps_pkg::TMR_W'(AMB_PERIOD);
  // sleep select shortens the reading interval, never lengthens it
  wire [lps_pkg::TMR_W-1:0] prox_period = lps_pkg::TMR_W'(PROX_PERIOD) >> ctrl_q.prox_sleep;

  lps_tick #(.W(lps_pkg::TMR_W)) u_amb_tmr
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .en      (ctrl_q.amb_en),
    .period  (amb_period),
    .tick    (amb_tick)
  );

  lps_tick #(.W(lps_pkg::TMR_W)) u_prox_tmr
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .en      (ctrl_q.prox_en),
    .period  (prox_period),
    .tick    (prox_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // proximity reading: emitter pulse then conversion

  wire prox_done = (pst_q == lps_pkg::P_CONV) &&
                   (pcnt_q == lps_pkg::TMR_W'(PROX_CONV - 1));

  always_comb
  begin
    pst_d  = pst_q;
    pcnt_d = pcnt_q + 1'b1;
    unique case (pst_q)
      lps_pkg::P_IDLE:
      begin
        pcnt_d = '0;
        if (prox_tick && ctrl_q.prox_en)
          pst_d = lps_pkg::P_EMIT;
      end
      lps_pkg::P_EMIT:
        if (pcnt_q == lps_pkg::TMR_W'(lps_pkg::EMIT_ON_CYC - 1))
          pst_d = lps_pkg::P_CONV;
      lps_pkg::P_CONV:
        if (prox_done)
          pst_d = lps_pkg::P_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pst_q  <= lps_pkg::P_IDLE;
      pcnt_q <= '0;
      emit_q <= 1'b0;
    end
    else
    begin
      pst_q  <= pst_d;
      pcnt_q <= pcnt_d;
      emit_q <= (pst_d == lps_pkg::P_EMIT);
    end
  end

  // results and latest trigger state of each channel
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      amb_data_q  <= 12'h000;
      prox_data_q <= 8'h00;
      amb_trig_q  <= 1'b0;
      prox_trig_q <= 1'b0;
    end
    else
    begin
      if (amb_tick)
      begin
        amb_data_q <= amb_sat;
        amb_trig_q <= amb_trig_now;
      end
      if (prox_done)
      begin
        prox_data_q <= prox_sat;
        prox_trig_q <= prox_trig_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // persistence and combined mode

  logic amb_hit;
  logic prox_hit;
  // combined mode judges each ambient sample against the latest proximity result
  wire  a_cond = ctrl_q.comb_mode ? (amb_trig_now && prox_trig_q) : amb_trig_now;
  // a disabled channel feeds a quiet sample every cycle, so a restart never counts old runs
  wire  amb_smp  = amb_tick || !ctrl_q.amb_en;
  wire  amb_cnd  = a_cond && ctrl_q.amb_en;
  wire  prox_smp = prox_done || !ctrl_q.prox_en;
  wire  prox_cnd = prox_trig_now && ctrl_q.prox_en;

  lps_persist u_amb_pers
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sample  (amb_smp),
    .cond    (amb_cnd),
    .sel     (ctrl_q.persist_sel),
    .hit     (amb_hit)
  );

  lps_persist u_prox_pers
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .sample  (prox_smp),
    .cond    (prox_cnd),
    .sel     (ctrl_q.persist_sel),
    .hit     (prox_hit)
  );

  wire [lps_pkg::IRQ_W-1:0] irq_ev = ctrl_q.comb_mode ?
    {amb_hit, 1'b0, 1'b0} : {1'b0, prox_hit, amb_hit};

  ////////////////////////////////////////////////////////////////////////////
  // status, mask and open-drain pin

  // a new event in the clear cycle survives: set wins
  assign stat_d = (stat_q & ~stat_clr) | irq_ev;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stat_q   <= '0;
      int_oe_q <= 1'b0;
    end
    else
    begin
      stat_q   <= stat_d;
      int_oe_q <= |(stat_d & mask_q);
    end
  end

  assign rd_data             = rd_data_q;
  assign emitter_sink_driver = emit_q;
  assign int_oe              = int_oe_q;
  assign int_o               = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [lps_pkg::TMR_W-1:0] emit_len_q;
  logic [lps_pkg::TMR_W-1:0] read_len_q;

  // long spans are counted here, since a delay of thousands of cycles is too slow to check
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      emit_len_q <= '0;
      read_len_q <= '0;
    end
    else
    begin
      emit_len_q <= emit_q ? emit_len_q + 1'b1 : '0;
      read_len_q <= (pst_q == lps_pkg::P_IDLE) ? '0 : read_len_q + 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_emit_width: assert property ($fell(emit_q) |->
    emit_len_q == lps_pkg::TMR_W'(lps_pkg::EMIT_ON_CYC))
    else $error("emitter on time wrong");
  a_conv_time: assert property ($fell(pst_q != lps_pkg::P_IDLE) |->
    read_len_q == lps_pkg::TMR_W'(PROX_CONV))
    else $error("proximity conversion time wrong");
  a_amb_range: assert property (amb_data_q <= lps_pkg::AMB_FULL)
    else $error("ambient result above full scale");
  a_amb_window: assert property (amb_tick && amb_trig_now |=> amb_trig_q)
    else $error("ambient window trigger missed");
  a_prox_thr: assert property (prox_done && (prox_sat <= thr_q.prox) |=> !prox_trig_q)
    else $error("proximity trigger without excess");
  a_irq_status: assert property (irq_ev != '0 |=> (stat_q & $past(irq_ev)) != '0)
    else $error("event lost from status");
  a_int_hold: assert property (int_oe_q && !wr_stat && (mask_q == $past(mask_q))
    |=> int_oe_q)
    else $error("interrupt released without clear");
  a_comb_only: assert property (ctrl_q.comb_mode |-> irq_ev[lps_pkg::IRQ_AMB] == 1'b0
    && irq_ev[lps_pkg::IRQ_PROX] == 1'b0)
    else $error("single channel event in combined mode");
  a_od_drive: assert property (int_o == 1'b0)
    else $error("interrupt pin driven high");

endmodule // lps_seq_top
`default_nettype wire

// ### lps_tick.sv
// period timer: one-cycle tick at the end of each programmed period
`default_nettype none
module lps_tick
#(
  parameter int W = 25
)
(
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         en,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  logic [W-1:0] cnt_q;
  logic         tick_q;
  wire          wrap = (cnt_q >= period - 1'b1);

  // restarts from zero whenever the channel is disabled
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= (!en || wrap) ? '0 : cnt_q + 1'b1;
      tick_q <= en && wrap;
    end
  end

  assign tick = tick_q;

  a_tick_gap: assert property (@(posedge sys_clk) disable iff (!rstn)
    tick |=> !tick)
    else $error("tick longer than one cycle");

endmodule // lps_tick
`default_nettype wire

// ### lps_persist.sv
// persistence filter: pulses once after 1, 4, 8 or 16 consecutive triggered samples
`default_nettype none
module lps_persist
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       sample,
  input  wire logic       cond,
  input  wire logic [1:0] sel,
  output logic            hit
);

  logic [4:0] cnt_q;
  logic       hit_q;
  wire  [4:0] need = (sel == 2'd0) ? 5'd1 :
                     (sel == 2'd1) ? 5'd4 :
                     (sel == 2'd2) ? 5'd8 : 5'd16;
  // count saturates so a long run raises the event only once
  wire        reach = sample && cond && (cnt_q == need - 5'd1);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 5'd0;
      hit_q <= 1'b0;
    end
    else
    begin
      if (sample)
        cnt_q <= !cond ? 5'd0 : (cnt_q < need) ? cnt_q + 5'd1 : cnt_q;
      hit_q <= reach;
    end
  end

  assign hit = hit_q;

  a_pers_count: assert property (@(posedge sys_clk) disable iff (!rstn)
    hit |-> $past(cnt_q) == need - 5'd1 && $past(cond) && $past(sample))
    else $error("persistence hit at wrong count");

endmodule // lps_persist
`default_nettype wire

// ### lps_int_pullup.sv
// interrupt line model: host-side pull-up on the open-drain pin
`default_nettype none
module lps_int_pullup
(
  input  wire logic int_o,
  input  wire logic int_oe,
  output logic      int_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released line goes to the pull-up level, never to the last driven value
  assign int_line = int_oe ? int_o : 1'b1;
endmodule // lps_int_pullup
`default_nettype wire

// ### light_proximity_sequencer_irq_test.sv
// self-checking bench for the light and proximity sequencer
`default_nettype none
module light_proximity_sequencer_irq_test;
  timeunit 1ns;
  timeprecision 1ns;
  // short periods keep the run small; sleep 7 divides the proximity period by 128
  localparam int AP = 200;
  localparam int PC = 3000;
  localparam int PP = 400000;
  localparam int PS = PP >> 7;
  typedef struct packed
  {
    logic        w;
    logic [7:0]  a;
    logic [15:0] d;
    logic [15:0] e;
  } lps_row_type;
  logic        sys_clk;
  logic        rstn;
  logic [7:0]  addr;
  logic [15:0] wr_data;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rd_data;
  logic [15:0] amb_raw;
  logic [9:0]  prox_raw;
  logic        emitter_sink_driver;
  logic        int_o;
  logic        int_oe;
  logic        int_line;
  int          err_total;
  int          checks_done;
  int          n;
  logic [15:0] v;
  lps_row_type rows [15] = '{
    {1'b0, 8'h00, 16'h0000, 16'h0000}, {1'b0, 8'h01, 16'h0000, 16'h0000},
    {1'b0, 8'h02, 16'h0000, 16'h0fff}, {1'b0, 8'h03, 16'h0000, 16'h00ff},
    {1'b0, 8'h04, 16'h0000, 16'h0000}, {1'b0, 8'h05, 16'h0000, 16'h0000},
    {1'b0, 8'h06, 16'h0000, 16'h0000}, {1'b0, 8'h07, 16'h0000, 16'h0000},
    {1'b0, 8'h08, 16'h0000, 16'h0000}, {1'b1, 8'h01, 16'h0100, 16'h0100},
    {1'b1, 8'h02, 16'h0800, 16'h0800}, {1'b1, 8'h03, 16'h0080, 16'h0080},
    {1'b1, 8'h04, 16'habcd, 16'h0000}, {1'b1, 8'h07, 16'h0007, 16'h0007},
    {1'b1, 8'hff, 16'h1234, 16'h0000}
  };

  lps_seq_top #(.AMB_PERIOD(AP), .PROX_PERIOD(PP), .PROX_CONV(PC)) lps_seq_top_inst
  (
    .sys_clk             (sys_clk),
    .rstn                (rstn),
    .addr                (addr),
    .wr_data             (wr_data),
    .wr_stb              (wr_stb),
    .rd_stb              (rd_stb),
    .rd_data             (rd_data),
    .amb_raw             (amb_raw),
    .prox_raw            (prox_raw),
    .emitter_sink_driver (emitter_sink_driver),
    .int_o               (int_o),
    .int_oe              (int_oe)
  );
  lps_int_pullup lps_int_pullup_inst
  (
    .int_o    (int_o),
    .int_oe   (int_oe),
    .int_line (int_line)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge sys_clk);
    wr_stb  <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample there
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    @(negedge sys_clk);
    chk(rd_data, e);
  endtask
  // sel 0 watches the emitter, sel 1 the interrupt line; a bound that runs out ends the run
  task automatic wait_on(input int sel, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (((sel == 0) ? emitter_sink_driver : int_line) !== lvl)
    begin
      @(negedge sys_clk);
      cnt++;
      if (cnt > lim)
      begin
        err_total++;
        $display("ERROR t=%0t wait ran out", $time);
        close_out();
      end
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    rstn = 1'b0; addr = 8'h00; wr_data = 16'h0000; wr_stb = 1'b0; rd_stb = 1'b0;
    amb_raw = 16'h0400; prox_raw = 10'h000; err_total = 0; checks_done = 0;
    cyc(4);
    rstn <= 1'b1;
    chk({15'h0000, int_line}, 16'h0001);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    $display("done: register rows");
    // persistence 1/4/8/16, below-low and above-high alternately, with saturation at s=2
    for (int s = 0; s < 4; s++)
    begin
      n = (s == 0) ? 1 : (4 << (s - 1));
      v = s[0] ? 16'h0050 : ((s == 2) ? 16'hffff : 16'h0900);
      @(posedge sys_clk);
      amb_raw <= v;
      wr(8'h00, 16'h0001 | 16'(s << 3));
      cyc((n - 1) * AP + AP / 2);
      rc(8'h06, 16'h0000);
      cyc(AP);
      rc(8'h06, 16'h0001);
      chk({15'h0000, int_line}, 16'h0000);
      rc(8'h04, (s == 2) ? 16'h0fff : v);
      wr(8'h00, 16'h0000);
      wr(8'h06, 16'h0001);
      rc(8'h06, 16'h0000);
      chk({15'h0000, int_line}, 16'h0001);
    end
    $display("done: ambient persistence");
    @(posedge sys_clk);
    amb_raw <= 16'h0400;
    wr(8'h00, 16'h0001);
    cyc(2 * AP + AP / 2);
    rc(8'h06, 16'h0000);
    rc(8'h04, 16'h0400);
    wr(8'h00, 16'h0000);
    $display("done: inside window");
    // proximity reading with an over-range code
    @(posedge sys_clk);
    prox_raw <= 10'h3ff;
    wr(8'h00, 16'h00e2);
    wait_on(0, 1'b1, PS + 20, n);
    chk({15'h0000, n >= PS - 4 && n <= PS + 4}, 16'h0001);
    wait_on(0, 1'b0, 3000, n);
    chk(16'(n), 16'd2500);
    cyc(PC - 2500 + 4);
    rc(8'h05, 16'h00ff);
    rc(8'h06, 16'h0002);
    chk({15'h0000, int_line}, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h06, 16'h0002);
    rc(8'h06, 16'h0000);
    $display("done: proximity");
    // combined mode with the event masked, then unmasked, then a reset mid-event
    wr(8'h07, 16'h0000);
    @(posedge sys_clk);
    amb_raw <= 16'h0900;
    wr(8'h00, 16'h00e7);
    cyc(PS + PC + 2 * AP);
    rc(8'h04, 16'h0900);
    rc(8'h06, 16'h0004);
    chk({15'h0000, int_line}, 16'h0001);
    wr(8'h07, 16'h0004);
    cyc(2);
    chk({15'h0000, int_line}, 16'h0000);
    rstn <= 1'b0;
    cyc(4);
    chk({15'h0000, int_line}, 16'h0001);
    chk({15'h0000, emitter_sink_driver}, 16'h0000);
    rstn <= 1'b1;
    rc(8'h00, 16'h0000);
    rc(8'h06, 16'h0000);
    $display("done: combined and reset");
    // a full-scale result equal to the reset threshold is not an excess
    wr(8'h00, 16'h00e2);
    cyc(PS + PC + 8);
    rc(8'h05, 16'h00ff);
    rc(8'h06, 16'h0000);
    $display("done: threshold boundary");
    close_out();
  end
endmodule // light_proximity_sequencer_irq_test
`default_nettype wire
